// [verilog/emi_params.svh]
// Purpose: Named constants for the Ethernet interrupt-enable and MAC config block
// Assumes: 32-bit AXI4-Lite register window, word aligned
// Notes:   Offsets are byte addresses; CLR/SET/INV views sit at +4/+8/+c
`ifndef EMI_PARAMS_SVH
`define EMI_PARAMS_SVH

// Register base offsets
`define EMI_OFF_IEN      8'h00
`define EMI_OFF_CFG2     8'h10
`define EMI_OFF_STAT     8'h20
`define EMI_OFF_EVSTAT   8'h30

// Variant sub-offsets (low nibble)
`define EMI_SUB_PLAIN    4'h0
`define EMI_SUB_CLR      4'h4
`define EMI_SUB_SET      4'h8
`define EMI_SUB_INV      4'hc

// Implemented-bit masks (unused bits read zero)
`define EMI_IEN_MASK     32'h0000_63ef
`define EMI_CFG2_MASK    32'h0000_73ff
`define EMI_IEN_RST      32'h0000_0000
`define EMI_CFG2_RST     32'h0000_40b2

// Field positions, interrupt enable / event status
`define EMI_B_TXBUSERR   14
`define EMI_B_RXBUSERR   13
`define EMI_B_EWMARK     9
`define EMI_B_FWMARK     8
`define EMI_B_RXDONE     7
`define EMI_B_PKTWAIT    6
`define EMI_B_RXACT      5
`define EMI_B_TXDONE     3
`define EMI_B_TXABORT    2
`define EMI_B_RXNOBUF    1
`define EMI_B_RXOVR      0

// Transmit-side event mask
`define EMI_TX_EVENTS    32'h0000_400c

// Field positions, MAC config two
`define EMI_B_UDEFER     14
`define EMI_B_BPSKIP     13
`define EMI_B_SKIPBO     12
`define EMI_B_SHORTPRE   9
`define EMI_B_PRECHK     8
`define EMI_B_AUTO_TAG_PAD    7
`define EMI_B_TAGPAD     6
`define EMI_B_PADON      5

// Frame constants
`define EMI_PRE_BYTE     8'h55
`define EMI_PRE_MAX      4'hc
`define EMI_VLAN_ID      16'h8100

// AXI responses
`define EMI_RESP_OKAY    2'b00
`define EMI_RESP_SLVERR  2'b10

`endif

// [verilog/emi_pkg.sv]
// Purpose: Types for the Ethernet interrupt-enable and MAC config block
// Assumes: Included constants header
// Notes:   Types only
`default_nettype none
package emi_pkg;
   // Pad decision for an outgoing frame
   typedef enum logic [1:0] {
      EMI_PAD_NONE   = 2'b00,
      EMI_PAD_PLAIN  = 2'b01,
      EMI_PAD_TAGGED = 2'b10
   } emi_pad_e;
   // Preamble checker state
   typedef enum logic [1:0] {
      EMI_PRE_IDLE = 2'b00,
      EMI_PRE_RUN  = 2'b01,
      EMI_PRE_DONE = 2'b10
   } emi_pre_e;
   typedef logic [31:0] emi_word_t;
endpackage
`default_nettype wire

// [verilog/emi_eth_cfg.sv]
// Purpose: Interrupt enables, event status and MAC config two for an Ethernet MAC
// Assumes: One 125 MHz clock, asynchronous active-high reset, AXI4-Lite slave
// Notes:   Byte-wide writes (wstrb not a 16/32-bit pattern) are ignored but answered OKAY
`include "emi_params.svh"
`default_nettype none

// Operation
// - Enabled transmit bus error raises the interrupt; disabled it does not.
// - Enabled receive bus error raises the interrupt; disabled it does not.
// - Empty and full watermark enables each gate their receive event.
// - Receive done, packet waiting, receive activity enables gate their events.
// - Transmit done and transmit abort enables gate their events.
// - No-buffer and FIFO overrun enables gate their receive errors.
// - Transmit enables touch only transmit events.
// - Receive enables touch only receive events.
// - Unused interrupt-enable bits read zero.
// - Unlimited defer set: defer forever; clear: abort at deferral limit; resets one.
// - Backpressure skip-backoff: retransmit at once after self-caused collision.
// - Skip backoff: retransmit at once after any collision; else exponential backoff.
// - Short-preamble enforce: accept only preambles under 12 bytes.
// - Preamble check: every byte 0x55 and error-free, else discard.
// - Auto pad compares octets after source address with 0x8100.
// - Auto and tagged pad ignored while pad enable is clear.
// - 16- and 32-bit accesses taken, including variants; byte writes ignored.
module emi_eth_cfg
   import emi_pkg::*;
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // AXI4-Lite write address / data / response
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // MAC event pulses, bit layout as the interrupt enable register
   input  wire emi_pkg::emi_word_t macEvents,
   // Receive preamble byte stream
   input  wire logic          preValid,
   input  wire logic [7:0]    preByte,
   input  wire logic          preErr,
   input  wire logic          preSfd,
   // Transmit frame type octets and pad request
   input  wire logic          typeValid,
   input  wire logic [15:0]   typeOctets,
   // Transmit policy outputs
   output logic               unlimitedDefer,
   output logic               collRetryNow,
   output logic               bpRetryNow,
   output emi_pkg::emi_pad_e  padMode,
   // Receive preamble verdict
   output logic               preAccept,
   output logic               preDiscard,
   // Interrupt
   output logic               irq
);
   import emi_pkg::*;

   emi_word_t ienR;
   emi_word_t cfgR;
   emi_word_t evStatR;
   logic       awHeldR;
   logic       wHeldR;
   logic [7:0] awAddrR;
   logic [31:0] wDataR;
   logic [3:0] wStrbR;
   logic       wrFire;
   logic       wrWide;
   logic [31:0] wrMask;
   logic [7:0] wrBase;
   logic [3:0] wrSub;
   emi_pre_e   preStateR;
   logic [3:0] preCountR;
   logic       preBadR;

   // Write address and data are latched independently; either may come first
   assign s_axi_awready = !awHeldR && !s_axi_bvalid;
   assign s_axi_wready  = !wHeldR && !s_axi_bvalid;
   assign wrFire = awHeldR && wHeldR && !s_axi_bvalid;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         awHeldR <= 1'b0;
         wHeldR  <= 1'b0;
         awAddrR <= 8'h00;
         wDataR  <= 32'h0000_0000;
         wStrbR  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeldR <= 1'b1;
            awAddrR <= s_axi_awaddr;
         end
         else if (wrFire)
            awHeldR <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeldR <= 1'b1;
            wDataR <= s_axi_wdata;
            wStrbR <= s_axi_wstrb;
         end
         else if (wrFire)
            wHeldR <= 1'b0;
      end
   end

   // Only full words or aligned halfwords count; lone bytes are dropped
   always_comb
   begin
      wrWide = 1'b0;
      wrMask = 32'h0000_0000;
      case (wStrbR)
         4'hf:
         begin
            wrWide = 1'b1;
            wrMask = 32'hffff_ffff;
         end
         4'h3:
         begin
            wrWide = 1'b1;
            wrMask = 32'h0000_ffff;
         end
         4'hc:
         begin
            wrWide = 1'b1;
            wrMask = 32'hffff_0000;
         end
         default:
         begin
            wrWide = 1'b0;
            wrMask = 32'h0000_0000;
         end
      endcase
   end
   assign wrBase = {awAddrR[7:4], 4'h0};
   assign wrSub  = awAddrR[3:0];

   // Apply a plain, clear, set or invert view to a register value
   function automatic emi_word_t applyWr(input emi_word_t cur, input emi_word_t imp);
      emi_word_t d;
      d = wDataR & wrMask;
      case (wrSub)
         `EMI_SUB_PLAIN: applyWr = ((cur & ~wrMask) | d) & imp;
         `EMI_SUB_CLR:   applyWr = cur & ~d;
         `EMI_SUB_SET:   applyWr = (cur | d) & imp;
         `EMI_SUB_INV:   applyWr = (cur ^ d) & imp;
         default:        applyWr = cur;
      endcase
   endfunction

   // Interrupt enable register; unimplemented bits forced low
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ienR <= `EMI_IEN_RST;
      else if (wrFire && wrWide && wrBase == `EMI_OFF_IEN)
         ienR <= applyWr(ienR, `EMI_IEN_MASK);
   end

   // MAC config two; unlimited defer and pad-on reset high
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cfgR <= `EMI_CFG2_RST;
      else if (wrFire && wrWide && wrBase == `EMI_OFF_CFG2)
         cfgR <= applyWr(cfgR, `EMI_CFG2_MASK);
   end

   // Sticky event flags, write-one-to-clear; a new event beats the clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         evStatR <= 32'h0000_0000;
      else if (wrFire && wrWide && wrBase == `EMI_OFF_EVSTAT && wrSub == `EMI_SUB_PLAIN)
         evStatR <= ((evStatR & ~(wDataR & wrMask)) | macEvents) & `EMI_IEN_MASK;
      else
         evStatR <= (evStatR | macEvents) & `EMI_IEN_MASK;
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `EMI_RESP_OKAY;
      end
      else if (wrFire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wrBase == `EMI_OFF_IEN || wrBase == `EMI_OFF_CFG2 ||
                          wrBase == `EMI_OFF_EVSTAT) ? `EMI_RESP_OKAY : `EMI_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Read channel: one cycle from address to data; variants read the base
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `EMI_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `EMI_RESP_OKAY;
         case ({s_axi_araddr[7:4], 4'h0})
            `EMI_OFF_IEN:    s_axi_rdata <= ienR & `EMI_IEN_MASK;
            `EMI_OFF_CFG2:   s_axi_rdata <= cfgR;
            `EMI_OFF_STAT:   s_axi_rdata <= evStatR & ienR;
            `EMI_OFF_EVSTAT: s_axi_rdata <= evStatR;
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `EMI_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Each enable gates only its own event bit, so transmit and receive
   // enables never cross paths
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(((evStatR | macEvents) & ienR) & `EMI_IEN_MASK);
   end

   // Transmit policy straight from config bits
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         unlimitedDefer <= 1'b1;
         collRetryNow   <= 1'b0;
         bpRetryNow     <= 1'b0;
      end
      else
      begin
         unlimitedDefer <= cfgR[`EMI_B_UDEFER];
         collRetryNow   <= cfgR[`EMI_B_SKIPBO];
         bpRetryNow     <= cfgR[`EMI_B_SKIPBO] | cfgR[`EMI_B_BPSKIP];
      end
   end

   // Pad decision: auto detection and tagged pad only count with pad-on
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         padMode <= EMI_PAD_NONE;
      else if (typeValid)
      begin
         if (!cfgR[`EMI_B_PADON])
            padMode <= EMI_PAD_NONE;
         else if (cfgR[`EMI_B_AUTO_TAG_PAD])
            padMode <= (typeOctets == `EMI_VLAN_ID) ? EMI_PAD_TAGGED : EMI_PAD_PLAIN;
         else if (cfgR[`EMI_B_TAGPAD])
            padMode <= EMI_PAD_TAGGED;
         else
            padMode <= EMI_PAD_PLAIN;
      end
   end

   // Preamble checker: counts bytes until the start delimiter
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         preStateR  <= EMI_PRE_IDLE;
         preCountR  <= 4'h0;
         preBadR    <= 1'b0;
         preAccept  <= 1'b0;
         preDiscard <= 1'b0;
      end
      else
      begin
         preAccept  <= 1'b0;
         preDiscard <= 1'b0;
         case (preStateR)
            EMI_PRE_IDLE, EMI_PRE_RUN:
            begin
               if (preValid && !preSfd)
               begin
                  preStateR <= EMI_PRE_RUN;
                  if (preCountR != 4'hf)
                     preCountR <= preCountR + 4'h1;
                  if (cfgR[`EMI_B_PRECHK] && (preErr || preByte != `EMI_PRE_BYTE))
                     preBadR <= 1'b1;
               end
               else if (preValid && preSfd)
               begin
                  preStateR <= EMI_PRE_DONE;
                  if (preBadR || (cfgR[`EMI_B_SHORTPRE] && preCountR >= `EMI_PRE_MAX))
                     preDiscard <= 1'b1;
                  else
                     preAccept <= 1'b1;
               end
            end
            EMI_PRE_DONE:
            begin
               preStateR <= EMI_PRE_IDLE;
               preCountR <= 4'h0;
               preBadR   <= 1'b0;
            end
            default:
               preStateR <= EMI_PRE_IDLE;
         endcase
      end
   end

   // Helper: high when any enabled flag is pending
   logic pendEn;
   assign pendEn = |(evStatR & ienR);

   a_irq_follows_flags: assert property (@(posedge clk) disable iff (rst)
      pendEn |=> irq)
      else $error("irq low while enabled flag pending");
   a_tx_event_gated: assert property (@(posedge clk) disable iff (rst)
      (macEvents[`EMI_B_TXBUSERR] && !ienR[`EMI_B_TXBUSERR] && !(|(evStatR & ienR))
       && !(|(macEvents & ienR))) |=> !irq)
      else $error("disabled tx bus error raised irq");
   a_rx_bus_raise: assert property (@(posedge clk) disable iff (rst)
      (macEvents[`EMI_B_RXBUSERR] && ienR[`EMI_B_RXBUSERR]) |=> irq)
      else $error("enabled rx bus error missed irq");
   a_rx_events_raise: assert property (@(posedge clk) disable iff (rst)
      (|(macEvents & ienR & ~`EMI_TX_EVENTS)) |=> irq)
      else $error("enabled rx event missed irq");
   a_tx_events_raise: assert property (@(posedge clk) disable iff (rst)
      (|(macEvents & ienR & `EMI_TX_EVENTS)) |=> irq)
      else $error("enabled tx event missed irq");
   a_ien_unused_zero: assert property (@(posedge clk) disable iff (rst)
      (ienR & ~`EMI_IEN_MASK) == 32'h0000_0000)
      else $error("unused enable bit set");
   a_defer_follows: assert property (@(posedge clk) disable iff (rst)
      $changed(cfgR[`EMI_B_UDEFER]) |=> unlimitedDefer == $past(cfgR[`EMI_B_UDEFER]))
      else $error("defer output wrong");
   a_backoff_skip: assert property (@(posedge clk) disable iff (rst)
      cfgR[`EMI_B_SKIPBO] |=> collRetryNow && bpRetryNow)
      else $error("skip backoff not applied");
   a_pad_off: assert property (@(posedge clk) disable iff (rst)
      (typeValid && !cfgR[`EMI_B_PADON]) |=> padMode == EMI_PAD_NONE)
      else $error("pad while pad off");
   a_vlan_detect: assert property (@(posedge clk) disable iff (rst)
      (typeValid && cfgR[`EMI_B_PADON] && cfgR[`EMI_B_AUTO_TAG_PAD]
       && typeOctets == `EMI_VLAN_ID) |=> padMode == EMI_PAD_TAGGED)
      else $error("tagged frame not detected");
   a_long_pre_drop: assert property (@(posedge clk) disable iff (rst)
      (preValid && preSfd && preStateR != EMI_PRE_DONE && cfgR[`EMI_B_SHORTPRE]
       && preCountR >= `EMI_PRE_MAX) |=> preDiscard)
      else $error("long preamble accepted");
   a_byte_write_ign: assert property (@(posedge clk) disable iff (rst)
      (wrFire && !wrWide) |=> $stable(ienR) && $stable(cfgR))
      else $error("byte write changed a register");
   a_event_sticky: assert property (@(posedge clk) disable iff (rst)
      (|(macEvents & `EMI_IEN_MASK)) |=>
      (evStatR & $past(macEvents) & `EMI_IEN_MASK) == ($past(macEvents) & `EMI_IEN_MASK))
      else $error("event flag lost or clear beat set");
endmodule
`default_nettype wire

// [sim/emi_phy_model.sv]
// Purpose: Network-side stand-in feeding preamble bytes and frame type octets
// Assumes: One byte per clock, indexes past the frame length never match
// Notes:   Idle lines toggle so a stale value cannot pass for a fresh one
`default_nettype none
module emi_phy_model
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Commands from the bench
   input  wire logic        frameGo,
   input  wire logic [4:0]  frameLen,
   input  wire logic [4:0]  badIdx,
   input  wire logic [4:0]  errIdx,
   input  wire logic        typeGo,
   input  wire logic [15:0] typeIn,
   // Lines into the block
   output logic             preValid,
   output logic [7:0]       preByte,
   output logic             preErr,
   output logic             preSfd,
   output logic             typeValid,
   output logic [15:0]      typeOctets
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       active;
   logic [4:0] cnt;

   // Preamble bytes, then the start delimiter at index frameLen
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         active <= 1'b0;
         cnt <= 5'h00;
         preValid <= 1'b0;
         preByte <= 8'h00;
         preErr <= 1'b0;
         preSfd <= 1'b0;
      end
      else if (frameGo || active)
      begin
         cnt <= frameGo ? 5'h01 : cnt + 5'h01;
         active <= frameGo || (cnt != frameLen);
         preValid <= 1'b1;
         preSfd <= !frameGo && (cnt == frameLen);
         preByte <= (!frameGo && cnt == frameLen) ? 8'hd5 :
                    (!frameGo && cnt == badIdx) ? 8'h54 : 8'h55; // Bad byte one bit off
         preErr <= !frameGo && (cnt == errIdx);
      end
      else
      begin
         preValid <= 1'b0;
         preSfd <= 1'b0;
         preErr <= 1'b0;
         preByte <= ~preByte; // Released line must not look valid
      end
   end

   // Type octets, one-cycle strobe
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         typeValid <= 1'b0;
         typeOctets <= 16'h0000;
      end
      else
      begin
         typeValid <= typeGo;
         typeOctets <= typeGo ? typeIn : ~typeOctets;
      end
   end
endmodule
`default_nettype wire

// [sim/emi_eth_cfg_bench.sv]
// Purpose: Self-checking bench for the interrupt-enable and MAC config block
// Assumes: AXI4-Lite master tasks, registers at 0x00/0x10/0x20/0x30
// Notes:   Inputs move only by non-blocking assignment after a rising edge
`include "emi_params.svh"
`default_nettype none
module emi_eth_cfg_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import emi_pkg::*;
   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, preValid, preErr, preSfd, typeValid;
   logic frameGo, typeGo, unlimitedDefer, collRetryNow, bpRetryNow, preAccept;
   logic preDiscard, irq;
   logic [7:0] awaddr, araddr, preByte;
   logic [31:0] wdata, rdata, rd32;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [4:0] frameLen, badIdx, errIdx;
   logic [15:0] typeIn, typeOctets;
   emi_word_t macEvents;
   emi_pad_e padMode;
   int failCount, testsRun;
   int bits [11] = '{14, 13, 9, 8, 7, 6, 5, 3, 2, 1, 0};

   emi_eth_cfg emi_eth_cfg_inst (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .macEvents(macEvents), .preValid(preValid),
      .preByte(preByte), .preErr(preErr), .preSfd(preSfd), .typeValid(typeValid),
      .typeOctets(typeOctets), .unlimitedDefer(unlimitedDefer),
      .collRetryNow(collRetryNow), .bpRetryNow(bpRetryNow), .padMode(padMode),
      .preAccept(preAccept), .preDiscard(preDiscard), .irq(irq));
   emi_phy_model emi_phy_model_inst (.clk(clk), .rst(rst), .frameGo(frameGo),
      .frameLen(frameLen), .badIdx(badIdx), .errIdx(errIdx), .typeGo(typeGo),
      .typeIn(typeIn), .preValid(preValid), .preByte(preByte), .preErr(preErr),
      .preSfd(preSfd), .typeValid(typeValid), .typeOctets(typeOctets));

   // 125 MHz clock
   always #4 clk = ~clk;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         failCount++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   // Write: address and data offered together, each dropped when taken
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // No local limit: only the watchdog may end a wait for the answer
      while (!tb)
      begin
         @(negedge clk); // Values here are those the next rising edge samples
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         rsp = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      logic ta, tr;
      tr = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr)
      begin
         @(negedge clk);
         ta = arvalid && arready;
         tr = rvalid;
         rd32 = rdata;
         rsp = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
      end
      chk(rd32, exp);
   endtask

   task settle(input int c);
      repeat (c) @(negedge clk);
   endtask

   task pulse(input emi_word_t m);
      @(posedge clk);
      macEvents <= m;
      @(posedge clk);
      macEvents <= '0;
      settle(2); // Pulse sampled and irq registered at the same edge
   endtask

   // One preamble then start delimiter, expecting one verdict pulse
   task frame(input logic [4:0] len, input logic [4:0] bad, input logic [4:0] err,
              input logic acc);
      int n;
      n = 0;
      @(posedge clk);
      frameLen <= len;
      badIdx <= bad;
      errIdx <= err;
      frameGo <= 1'b1;
      @(posedge clk);
      frameGo <= 1'b0;
      while (!(preAccept || preDiscard) && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      chkb(preAccept, acc);
      chkb(preDiscard, !acc);
   endtask

   task typ(input logic [15:0] v, input emi_pad_e exp);
      @(posedge clk);
      typeIn <= v;
      typeGo <= 1'b1;
      @(posedge clk);
      typeGo <= 1'b0;
      settle(3);
      chk({30'h0, padMode}, {30'h0, exp});
   endtask

   task finalReport();
      $display("counts: comparisons=%0d mismatches=%0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Watchdog: whole sequence needs well under a thousand cycles
   initial
   begin
      repeat (30000) @(posedge clk);
      failCount++;
      $display("watchdog expired at t=%0t", $time);
      finalReport();
   end

   initial
   begin
      {clk, awvalid, wvalid, bready, arvalid, rready, frameGo, typeGo} = '0;
      {awaddr, araddr, wdata, wstrb, frameLen, badIdx, errIdx, typeIn} = '0;
      macEvents = '0;
      rst = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // Reset values, access widths and variant views
      rd(8'h00, `EMI_IEN_RST);
      rd(8'h10, `EMI_CFG2_RST);
      chkb(unlimitedDefer, 1'b1);
      chkb(irq, 1'b0);
      wr(8'h00, 32'hffff_ffff, 4'hf);
      rd(8'h00, `EMI_IEN_MASK);
      wr(8'h00, 32'h0000_0000, 4'h1);
      rd(8'h00, `EMI_IEN_MASK);
      wr(8'h04, 32'h0000_00ff, 4'h3);
      rd(8'h00, 32'h0000_6300);
      wr(8'h08, 32'h0000_000c, 4'h3);
      rd(8'h0c, 32'h0000_630c);
      wr(8'h0c, 32'h0000_ffff, 4'h3);
      rd(8'h00, 32'h0000_00e3);
      rd(8'h40, 32'h0000_0000);
      chk({30'h0, rsp}, {30'h0, `EMI_RESP_SLVERR});
      wr(8'h40, 32'h0000_0001, 4'hf);
      chk({30'h0, rsp}, {30'h0, `EMI_RESP_SLVERR});
      wr(8'h00, 32'h0000_0001, 4'h1);
      chk({30'h0, rsp}, {30'h0, `EMI_RESP_OKAY});
      rd(8'h00, 32'h0000_00e3);
      $display("test registers done");
      // Each event alone: enabled raises irq, masked with all others on does not
      wr(8'h00, 32'h0, 4'hf);
      wr(8'h30, 32'hffff_ffff, 4'hf);
      foreach (bits[i])
      begin
         wr(8'h00, 32'h1 << bits[i], 4'hf);
         pulse(32'h1 << bits[i]);
         chkb(irq, 1'b1);
         rd(8'h20, 32'h1 << bits[i]);
         wr(8'h30, 32'h1 << bits[i], 4'hf);
         settle(2);
         chkb(irq, 1'b0);
         wr(8'h00, `EMI_IEN_MASK ^ (32'h1 << bits[i]), 4'hf);
         pulse(32'h1 << bits[i]);
         chkb(irq, 1'b0);
         wr(8'h30, 32'h1 << bits[i], 4'hf);
      end
      $display("test interrupts done");
      // Transmit policy outputs
      wr(8'h18, 32'h0000_2000, 4'h3);
      settle(2);
      chkb(bpRetryNow, 1'b1);
      chkb(collRetryNow, 1'b0);
      wr(8'h18, 32'h0000_1000, 4'h3);
      settle(2);
      chkb(collRetryNow, 1'b1);
      wr(8'h14, 32'h0000_7000, 4'hc);
      wr(8'h14, 32'h0000_7000, 4'h3);
      settle(2);
      chkb(unlimitedDefer, 1'b0);
      chkb(bpRetryNow, 1'b0);
      chkb(collRetryNow, 1'b0);
      wr(8'h18, 32'h0000_4000, 4'hf);
      settle(2);
      chkb(unlimitedDefer, 1'b1);
      $display("test policy done");
      // Preamble checks off, then content, then length
      frame(5'd7, 5'd3, 5'd31, 1'b1);
      frame(5'd12, 5'd31, 5'd31, 1'b1);
      wr(8'h18, 32'h0000_0100, 4'h3);
      frame(5'd7, 5'd31, 5'd31, 1'b1);
      frame(5'd7, 5'd2, 5'd31, 1'b0);
      frame(5'd7, 5'd31, 5'd4, 1'b0);
      wr(8'h14, 32'h0000_0100, 4'h3);
      wr(8'h18, 32'h0000_0200, 4'h3);
      frame(5'd11, 5'd31, 5'd31, 1'b1);
      frame(5'd12, 5'd31, 5'd31, 1'b0);
      $display("test preamble done");
      // Padding with auto detect on, then pad enable off
      typ(16'h8100, EMI_PAD_TAGGED);
      typ(16'h0800, EMI_PAD_PLAIN);
      wr(8'h14, 32'h0000_0020, 4'h3);
      typ(16'h8100, EMI_PAD_NONE);
      // Pad on, detection off: tagged pad alone decides
      wr(8'h18, 32'h0000_0060, 4'h3);
      wr(8'h14, 32'h0000_0080, 4'h3);
      typ(16'h0800, EMI_PAD_TAGGED);
      wr(8'h14, 32'h0000_0040, 4'h3);
      typ(16'h8100, EMI_PAD_PLAIN);
      $display("test padding done");
      finalReport();
   end
endmodule
`default_nettype wire
